// *** common/spe_defs.vh ***
// Register offsets, field positions and reset values of the port error handler
`ifndef SPE_DEFS_VH
`define SPE_DEFS_VH

`define SPE_ADDR_W          12
`define SPE_OFF_STATUS      12'h000
`define SPE_OFF_ENABLE      12'h004
`define SPE_OFF_CTRL        12'h008
`define SPE_OFF_LINKERR     12'h00c
`define SPE_OFF_FBS         12'h010
`define SPE_OFF_ISSUE       12'h014
`define SPE_OFF_QACT        12'h018

// Status and enable bit positions
`define SPE_ST_OVERFLOW     0
`define SPE_ST_NONFATAL     1
`define SPE_ST_FATAL        2
`define SPE_ST_HBUS_FATAL   3
`define SPE_ST_HDATA        4
`define SPE_ST_TASKFILE     5
`define SPE_ST_W            6

// Control bit positions
`define SPE_CT_RUN          0
`define SPE_CT_RUNNING      1
`define SPE_CT_FBS_EN       2
`define SPE_CT_GIE          3
`define SPE_CT_HALTED       4
`define SPE_CT_ESCAPING     5
`define SPE_CT_RETRY        6

// Link error register bit positions
`define SPE_LE_RULE         0
`define SPE_LE_RERR         1
`define SPE_LE_CRC          2

// Failed device register fields
`define SPE_FB_SDE          0
`define SPE_FB_DEV_LO       4

`define SPE_RST_ZERO        32'h0000_0000

`endif

// *** rtl/spe_port_error.v ***
// Port error detection, classification, abort and fatal halt logic
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - Read overflow sets overflow status, interrupt
// - Write overflow flag optional; we set it
// - Switching overflow records device, sets single fault
// - Queued commands: overflow optional, underflow undetected
// - Read underflow writes back last FIS bytes
// - Non-Dword intermediate FIS: rule violation, fatal, stop
// - PIO size mismatch: R_ERR, rule violation, fatal
// - Escape on D2H or H2D data is fatal
// - Escape on H2D non-data: fatal or single fault
// - R_ERR on outgoing data FIS: fatal halt
// - Switching on: R_ERR logged, running continues
// - R_ERR on non-data FIS: nonfatal, retransmit
// - Received CRC: data fatal, non-data nonfatal
// - Orphan DMA setup fatal; others dropped quietly
// - Abort sends escape, halts when device quiet
// - Fatal status halts, clears running, no new commands
// - Restart only by run bit low then high
// - Nonfatal or overflow alone keeps port running
// - Run bit low clears issued slots mask
`include "spe_defs.vh"

module spe_port_error #(
	parameter NSLOT  = 32,
	parameter DEV_W  = 4,
	parameter CNT_W  = 22
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire [11:0]      paddr,
	input  wire             psel,
	input  wire             penable,
	input  wire             pwrite,
	input  wire [31:0]      pwdata,
	output reg  [31:0]      prdata,
	output reg              pready,
	output reg              pslverr,
	input  wire             ev_overflow,
	input  wire             ev_overflow_write,
	input  wire             ev_overflow_queued,
	input  wire             ev_underflow_read,
	input  wire [CNT_W-1:0] ev_last_fis_bytes,
	input  wire             ev_odd_dword,
	input  wire             ev_pio_size_bad,
	input  wire             ev_escape_d2h,
	input  wire             ev_escape_h2d_data,
	input  wire             ev_escape_h2d_ctl,
	input  wire             ev_rerr_data,
	input  wire             ev_rerr_ctl,
	input  wire             ev_crc_data,
	input  wire             ev_crc_ctl,
	input  wire             ev_orphan_dma_setup,
	input  wire             ev_orphan_other,
	input  wire             ev_d2h_reg_err,
	input  wire             ev_hbus_fatal,
	input  wire             ev_hdata_err,
	input  wire             ev_taskfile_err,
	input  wire [DEV_W-1:0] ev_dev,
	input  wire             link_quiet,
	input  wire [NSLOT-1:0] slot_issue_set,
	input  wire [NSLOT-1:0] slot_done,
	input  wire [NSLOT-1:0] queued_set,
	output reg              irq,
	output reg              sync_escape,
	output reg              send_rerr,
	output reg              retransmit,
	output reg              prd_wb_valid,
	output reg  [CNT_W-1:0] prd_wb_count,
	output reg              allow_issue,
	output reg              allow_dma_setup,
	output reg              drop_fis
);

	localparam S_IDLE   = 3'b001;
	localparam S_ESCAPE = 3'b010;
	localparam S_HALT   = 3'b100;

	reg [`SPE_ST_W-1:0] status_q;
	reg [`SPE_ST_W-1:0] status_d;
	reg [`SPE_ST_W-1:0] enable_q;
	reg [2:0]           linkerr_q;
	reg [2:0]           linkerr_d;
	reg [DEV_W-1:0]     fail_dev_q;
	reg                 sde_q;
	reg                 run_q;
	reg                 run_prev_q;
	reg                 fbs_q;
	reg                 gie_q;
	reg                 running_q;
	reg [2:0]           state_q;
	reg [2:0]           state_d;
	reg [NSLOT-1:0]     issue_q;
	reg [NSLOT-1:0]     qact_q;
	reg                 retry_pend_q;

	wire acc      = psel & penable;
	wire wr       = acc & pwrite;
	wire fbs_on   = fbs_q;
	wire run_rise = run_q & ~run_prev_q;

	function sel;
		input [11:0] a;
		input [11:0] off;
		begin
			sel = (a == off);
		end
	endfunction

	reg link_fatal;
	reg nonfatal;
	reg ovf_ev;
	reg single_fault;
	reg any_fatal_st;

	// Fatal causes that request an abort on the link
	always @* begin
		link_fatal = 1'b0;
		if (ev_odd_dword)
			link_fatal = 1'b1;
		if (ev_pio_size_bad)
			link_fatal = 1'b1;
		if (ev_escape_d2h | ev_escape_h2d_data)
			link_fatal = 1'b1;
		if (ev_escape_h2d_ctl & ~fbs_on)
			link_fatal = 1'b1;
		if (ev_rerr_data & ~fbs_on)
			link_fatal = 1'b1;
		if (ev_crc_data)
			link_fatal = 1'b1;
		if (ev_orphan_dma_setup)
			link_fatal = 1'b1;
	end

	// Control-frame faults are nonfatal (H2D escape only with switching on), so they do not stop the port; only R_ERR on them is retransmitted
	always @* begin
		nonfatal = 1'b0;
		if (ev_escape_h2d_ctl & fbs_on)
			nonfatal = 1'b1;
		if (ev_rerr_ctl)
			nonfatal = 1'b1;
		if (ev_crc_ctl)
			nonfatal = 1'b1;
	end

	// Write and queued overflow reporting is optional; reporting it costs nothing here
	always @* begin
		ovf_ev = ev_overflow;
		if (ev_overflow_write)
			ovf_ev = 1'b1;
		if (ev_overflow_queued)
			ovf_ev = 1'b1;
	end

	// Under switching only the failing device is marked; the others keep running
	always @* begin
		single_fault = 1'b0;
		if (fbs_on & ovf_ev)
			single_fault = 1'b1;
		if (fbs_on & ev_escape_h2d_ctl)
			single_fault = 1'b1;
		if (fbs_on & ev_d2h_reg_err)
			single_fault = 1'b1;
	end

	always @* begin
		any_fatal_st = status_q[`SPE_ST_FATAL] | status_q[`SPE_ST_HBUS_FATAL]
			| status_q[`SPE_ST_HDATA] | status_q[`SPE_ST_TASKFILE];
	end

	// Status sets win over write-one-to-clear in the same cycle
	always @* begin
		status_d = status_q;
		if (wr && sel(paddr, `SPE_OFF_STATUS))
			status_d = status_q & ~pwdata[`SPE_ST_W-1:0];
		if (ovf_ev)
			status_d[`SPE_ST_OVERFLOW] = 1'b1;
		if (nonfatal)
			status_d[`SPE_ST_NONFATAL] = 1'b1;
		if (link_fatal)
			status_d[`SPE_ST_FATAL] = 1'b1;
		if (ev_hbus_fatal)
			status_d[`SPE_ST_HBUS_FATAL] = 1'b1;
		if (ev_hdata_err)
			status_d[`SPE_ST_HDATA] = 1'b1;
		if (ev_taskfile_err && !fbs_on)
			status_d[`SPE_ST_TASKFILE] = 1'b1;
	end

	always @* begin
		linkerr_d = linkerr_q;
		if (wr && sel(paddr, `SPE_OFF_LINKERR))
			linkerr_d = linkerr_q & ~pwdata[2:0];
		if (ev_odd_dword | ev_pio_size_bad)
			linkerr_d[`SPE_LE_RULE] = 1'b1;
		if (ev_rerr_data | ev_rerr_ctl)
			linkerr_d[`SPE_LE_RERR] = 1'b1;
		if (ev_crc_data | ev_crc_ctl)
			linkerr_d[`SPE_LE_CRC] = 1'b1;
	end

	wire [NSLOT-1:0] issue_d;
	wire [NSLOT-1:0] qact_d;

	genvar gi;
	generate
		for (gi = 0; gi < NSLOT; gi = gi + 1) begin : g_slot
			// Run low empties every slot, so a restart never replays stale work
			assign issue_d[gi] = run_q & ~slot_done[gi]
				& (issue_q[gi] | (running_q & slot_issue_set[gi]));
			assign qact_d[gi]  = run_q & ~slot_done[gi] & (qact_q[gi] | queued_set[gi]);
		end
	endgenerate

	// Abort and halt sequencing
	always @* begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				if (link_fatal)
					state_d = S_ESCAPE;
				else if (any_fatal_st | ev_hbus_fatal | ev_hdata_err)
					state_d = S_HALT;
			end
			S_ESCAPE: begin
				if (link_quiet)
					state_d = S_HALT;
			end
			S_HALT: begin
				if (!run_q)
					state_d = S_IDLE;
			end
			default: state_d = S_IDLE;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q     <= {`SPE_ST_W{1'b0}};
			enable_q     <= {`SPE_ST_W{1'b0}};
			linkerr_q    <= 3'h0;
			fail_dev_q   <= {DEV_W{1'b0}};
			sde_q        <= 1'b0;
			run_q        <= 1'b0;
			run_prev_q   <= 1'b0;
			fbs_q        <= 1'b0;
			gie_q        <= 1'b0;
			running_q    <= 1'b0;
			state_q      <= S_IDLE;
			issue_q      <= {NSLOT{1'b0}};
			qact_q       <= {NSLOT{1'b0}};
			retry_pend_q <= 1'b0;
		end else begin
			status_q   <= status_d;
			linkerr_q  <= linkerr_d;
			state_q    <= state_d;
			run_prev_q <= run_q;
			if (wr && sel(paddr, `SPE_OFF_ENABLE))
				enable_q <= pwdata[`SPE_ST_W-1:0];
			if (wr && sel(paddr, `SPE_OFF_CTRL)) begin
				run_q <= pwdata[`SPE_CT_RUN];
				fbs_q <= pwdata[`SPE_CT_FBS_EN];
				gie_q <= pwdata[`SPE_CT_GIE];
			end
			if (single_fault) begin
				fail_dev_q <= ev_dev;
				sde_q      <= 1'b1;
			end else if (wr && sel(paddr, `SPE_OFF_FBS) && pwdata[`SPE_FB_SDE]) begin
				sde_q <= 1'b0;
			end
			// Running drops on any fatal path; comes back only on a fresh run edge
			if (state_d != S_IDLE || !run_q)
				running_q <= 1'b0;
			else if (run_rise && state_q == S_IDLE)
				running_q <= 1'b1;
			issue_q <= issue_d;
			qact_q  <= qact_d;
			if (ev_rerr_ctl)
				retry_pend_q <= 1'b1;
			else if (retransmit)
				retry_pend_q <= 1'b0;
		end
	end

	// Registered outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq             <= 1'b0;
			sync_escape     <= 1'b0;
			send_rerr       <= 1'b0;
			retransmit      <= 1'b0;
			prd_wb_valid    <= 1'b0;
			prd_wb_count    <= {CNT_W{1'b0}};
			allow_issue     <= 1'b0;
			allow_dma_setup <= 1'b0;
			drop_fis        <= 1'b0;
		end else begin
			irq          <= gie_q & |(status_d & enable_q);
			sync_escape  <= (state_d == S_ESCAPE);
			send_rerr    <= ev_pio_size_bad;
			retransmit   <= ev_rerr_ctl;
			prd_wb_valid <= ev_underflow_read;
			if (ev_underflow_read)
				prd_wb_count <= ev_last_fis_bytes;
			allow_issue     <= running_q & (state_d == S_IDLE);
			allow_dma_setup <= running_q & (state_d == S_IDLE);
			drop_fis        <= ev_orphan_other;
		end
	end

	reg [31:0] issue_rd;
	reg [31:0] qact_rd;
	reg [31:0] rdata_d;
	reg        rerr_d;

	always @* begin
		issue_rd = 32'h0000_0000;
		qact_rd  = 32'h0000_0000;
		issue_rd[NSLOT-1:0] = issue_q;
		qact_rd[NSLOT-1:0]  = qact_q;
	end

	// Read data is captured in the setup cycle so it stands through the access cycle
	always @* begin
		rdata_d = `SPE_RST_ZERO;
		rerr_d  = 1'b0;
		case (paddr)
			`SPE_OFF_STATUS: begin
				rdata_d[`SPE_ST_W-1:0] = status_q;
			end
			`SPE_OFF_ENABLE: begin
				rdata_d[`SPE_ST_W-1:0] = enable_q;
			end
			`SPE_OFF_CTRL: begin
				rdata_d[`SPE_CT_RUN]      = run_q;
				rdata_d[`SPE_CT_RUNNING]  = running_q;
				rdata_d[`SPE_CT_FBS_EN]   = fbs_q;
				rdata_d[`SPE_CT_GIE]      = gie_q;
				rdata_d[`SPE_CT_HALTED]   = (state_q == S_HALT);
				rdata_d[`SPE_CT_ESCAPING] = (state_q == S_ESCAPE);
				rdata_d[`SPE_CT_RETRY]    = retry_pend_q;
			end
			`SPE_OFF_LINKERR: begin
				rdata_d[2:0] = linkerr_q;
			end
			`SPE_OFF_FBS: begin
				rdata_d[`SPE_FB_SDE]           = sde_q;
				rdata_d[`SPE_FB_DEV_LO+:DEV_W] = fail_dev_q;
			end
			`SPE_OFF_ISSUE: begin
				rdata_d = issue_rd;
			end
			`SPE_OFF_QACT: begin
				rdata_d = qact_rd;
			end
			default: begin
				rerr_d = 1'b1;
			end
		endcase
	end

	// APB slave: zero wait states, unmapped addresses read zero with an error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= `SPE_RST_ZERO;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			prdata  <= `SPE_RST_ZERO;
			if (psel && !penable) begin
				prdata  <= rdata_d;
				pslverr <= rerr_d;
			end
		end
	end

endmodule

// *** testbench/spe_dev_model.sv ***
// Behavioural link partner that quiesces a while after an abort escape
`timescale 1ns/1ns
module spe_dev_model (
	input  wire  pclk,
	input  wire  presetn,
	input  wire  sync_escape,
	input  wire  slow,
	output logic link_quiet
);
	logic [2:0] cnt_q;
	// The device finishes its own frame first, so the abort never ends at once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_q <= 3'h0;
		else
			cnt_q <= sync_escape ? cnt_q + 3'h1 : 3'h0;
	end
	assign link_quiet = sync_escape && (cnt_q == (slow ? 3'h4 : 3'h1));
endmodule

// *** testbench/spe_props.sv ***
// Concurrent checks on the port error handler outputs
`timescale 1ns/1ns
module spe_props #(parameter CNT_W = 22) (
	input wire             pclk,
	input wire             presetn,
	input wire             ev_overflow,
	input wire             ev_pio_size_bad,
	input wire             ev_rerr_ctl,
	input wire             ev_underflow_read,
	input wire [CNT_W-1:0] ev_last_fis_bytes,
	input wire             ev_orphan_other,
	input wire             ev_odd_dword,
	input wire             ev_crc_ctl,
	input wire             link_quiet,
	input wire             send_rerr,
	input wire             retransmit,
	input wire             prd_wb_valid,
	input wire [CNT_W-1:0] prd_wb_count,
	input wire             drop_fis,
	input wire             sync_escape,
	input wire             allow_issue,
	input wire             allow_dma_setup
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rerr; ev_pio_size_bad |=> send_rerr; endproperty
	a_rerr: assert property (p_rerr) else $error("no R_ERR after size mismatch");
	property p_retx; ev_rerr_ctl |=> retransmit; endproperty
	a_retx: assert property (p_retx) else $error("no retransmit");
	property p_wb;
		ev_underflow_read |=> prd_wb_valid && prd_wb_count == $past(ev_last_fis_bytes);
	endproperty
	a_wb: assert property (p_wb) else $error("bad byte count write back");
	property p_drop; ev_orphan_other |=> drop_fis; endproperty
	a_drop: assert property (p_drop) else $error("orphan frame not dropped");
	property p_esc; allow_issue && ev_odd_dword |=> sync_escape; endproperty
	a_esc: assert property (p_esc) else $error("no escape on fatal");
	property p_hold; sync_escape && !link_quiet |=> sync_escape; endproperty
	a_hold: assert property (p_hold) else $error("escape ended early");
	property p_idle; sync_escape && link_quiet |=> !sync_escape; endproperty
	a_idle: assert property (p_idle) else $error("escape not ended");
	property p_halt;
		$fell(sync_escape) |-> ##[0:2] (!allow_issue && !allow_dma_setup);
	endproperty
	a_halt: assert property (p_halt) else $error("issue allowed after abort");
	property p_keep; allow_issue && (ev_crc_ctl || ev_overflow) |=> allow_issue; endproperty
	a_keep: assert property (p_keep) else $error("nonfatal error halted");
endmodule
bind spe_port_error spe_props #(.CNT_W(CNT_W)) spe_props_inst (.pclk, .presetn,
	.ev_overflow, .ev_pio_size_bad, .ev_rerr_ctl, .ev_underflow_read, .ev_last_fis_bytes,
	.ev_orphan_other, .ev_odd_dword, .ev_crc_ctl, .link_quiet, .send_rerr, .retransmit,
	.prd_wb_valid, .prd_wb_count, .drop_fis, .sync_escape, .allow_issue, .allow_dma_setup);

// *** testbench/tb_top.sv ***
// Self-checking bench for the port error handler
`timescale 1ns/1ns
module tb_top;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, e;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, r;
	logic [19:0] ev = 0;
	logic [3:0]  dev = 0;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq, esc, lq, ai, ad;
	int          n_mismatch = 0, checks = 0, cyc = 0;
	always #5 pclk = ~pclk;
	spe_port_error #(.NSLOT(8)) spe_port_error_inst (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ev_overflow(ev[0]),
		.ev_odd_dword(ev[1]), .ev_pio_size_bad(ev[2]), .ev_escape_d2h(ev[3]),
		.ev_escape_h2d_data(ev[4]), .ev_rerr_data(ev[5]), .ev_crc_data(ev[6]),
		.ev_orphan_dma_setup(ev[7]), .ev_hbus_fatal(ev[8]), .ev_hdata_err(ev[9]),
		.ev_taskfile_err(ev[10]), .ev_rerr_ctl(ev[11]), .ev_crc_ctl(ev[12]),
		.ev_escape_h2d_ctl(ev[13]), .ev_orphan_other(ev[14]), .ev_underflow_read(ev[15]),
		.ev_overflow_write(ev[16]), .ev_overflow_queued(ev[17]), .ev_d2h_reg_err(ev[18]),
		.ev_last_fis_bytes({18'h0, dev}), .ev_dev(dev), .link_quiet(lq),
		.slot_issue_set({7'h0, ev[19]}), .slot_done(8'h00), .queued_set(8'h00), .irq(irq),
		.sync_escape(esc), .send_rerr(), .retransmit(), .prd_wb_valid(), .prd_wb_count(),
		.allow_issue(ai), .allow_dma_setup(ad), .drop_fis());
	spe_dev_model spe_dev_model_inst (.pclk(pclk), .presetn(presetn), .sync_escape(esc),
		.slow(slow), .link_quiet(lq));
	task stop_test;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] x, input logic [31:0] s);
		checks++;
		if (s !== x) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, x, s);
		end
	endtask
	// Request held until pready is sampled; one idle edge keeps psel from toggling twice
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata; e = pslverr;
		psel <= 0; penable <= 0;
		@(posedge pclk);
	endtask
	task pulse(input int i);
		ev[i] <= 1;
		@(posedge pclk);
		ev <= '0;
		@(posedge pclk);
	endtask
	function logic [5:0] ex(input int i);
		case (i)
			0, 16, 17: ex = 6'h01;
			11, 12:    ex = 6'h02;
			8:         ex = 6'h08;
			9:         ex = 6'h10;
			10:        ex = 6'h20;
			14, 15:    ex = 6'h00;
			default:   ex = 6'h04;
		endcase
	endfunction
	task s_start;
		apb(1, 12'h008, 32'h9); apb(1, 12'h004, 0); pulse(0);
		chk("irq masked", 0, irq);
		apb(1, 12'h004, 32'h3f);
		@(posedge pclk);
		chk("irq on", 1, irq);
		apb(1, 12'h000, 32'h3f);
		chk("irq clear", 0, irq);
		pulse(19); apb(0, 12'h014, 0);
		chk("issued", 1, r);
		apb(0, 12'h01c, 0);
		chk("unmapped err", 1, e);
		chk("unmapped data", 0, r);
	endtask
	task s_all;
		for (int i = 0; i < 18; i++) begin
			slow <= i[0];
			pulse(i); apb(0, 12'h000, 0);
			chk("status", ex(i), r[5:0]);
			chk("irq", |ex(i), irq);
			if (i == 1 || i == 2) begin
				apb(0, 12'h00c, 0);
				chk("rule bit", 1, r[0]);
			end
			apb(0, 12'h008, 0);
			if (ex(i) & 6'h3c) begin
				for (int k = 0; k < 20 && r[1]; k++) apb(0, 12'h008, 0);
				chk("running", 0, r[1]);
				chk("allow issue", 0, ai);
				chk("allow dma setup", 0, ad);
				apb(1, 12'h008, 32'h9); apb(0, 12'h008, 0);
				chk("no restart", 0, r[1]);
				apb(1, 12'h008, 32'h8); apb(0, 12'h014, 0);
				chk("issued clr", 0, r);
				apb(1, 12'h000, 32'h3f); apb(1, 12'h00c, 32'h7); apb(1, 12'h008, 32'h9);
				apb(0, 12'h008, 0);
				chk("restart", 1, r[1]);
			end else begin
				chk("keeps running", 1, r[1]);
				apb(1, 12'h000, 32'h3f);
				if (i == 16) begin
					apb(1, 12'h008, 32'h8);
					apb(1, 12'h008, 32'h9);
				end
			end
		end
	endtask
	task s_fbs;
		dev <= 4'h5; apb(1, 12'h008, 32'hd); pulse(0); apb(0, 12'h010, 0);
		chk("fbs ovf", 32'h51, r);
		apb(1, 12'h000, 32'h3f); apb(1, 12'h010, 1); pulse(13); apb(0, 12'h000, 0);
		chk("esc ctl", 6'h02, r[5:0]);
		apb(0, 12'h010, 0);
		chk("fbs esc", 32'h51, r);
		apb(1, 12'h010, 1); pulse(5);
		chk("rerr continues", 1, ai);
		pulse(18); apb(0, 12'h010, 0);
		chk("fbs reg", 32'h51, r);
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test;
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		s_start;
		s_all;
		s_fbs;
		stop_test;
	end
endmodule
